//--- src/osdp_pkg.sv
// Shared constants and carrier types for the OSD pixel colour stage
// What this block does
// - ROM and 1-bit glyph pixel bit picks character foreground or background colour.
// - Attribute selects one of 8 groups, plus foreground and background entry within it.
// - 2-bit glyph pixel value picks one of 4 entries in the chosen group.
// - For 2-bit glyphs attribute selects one of 8 four-entry groups.
// - 4-bit glyph pixel value picks one of 16 entries in the chosen group.
// - For 4-bit glyphs attribute selects one of 4 sixteen-entry groups; last is 48-63.
// - Entries 48-63 are fetched at palette base plus 0x40..0x5e, two bytes each.
// - Soft glyph height is 9 plus code lines; width fixed at 12 pixels.
// - ROM glyph height is 9 plus its own code lines; width 12 pixels.
// - Lines per character row come from the soft glyph height code only.
// - ROM glyph lines beyond its height show background colour.
// - Shadow off at enable 0; at 1 only ROM and 1-bit glyphs get shadow.
// - Shadow direction 0 casts east, 1 casts west.
// - Shadow pixels use a 6-bit colour index reaching any palette entry.
// - Shadow never crosses into a neighbouring character cell.
// - Line doubling enable 1 shows each line twice; 0 shows it once.
// - Doubling applies only to lines inside the character display area.
// - Soft glyphs come in 1, 2 and 4 bit formats with own base pointers.
// - Each soft glyph starts on a fresh byte; a trailing unused nibble is skipped.
// - 1-bit pixels pack 12 per line across bytes, lowest pixel in bit 7.
// - 2-bit pixels pack four per byte, pixel bit 0 in bit 7, bit 1 in bit 6.
// - 48 programmable two-byte entries stored consecutively from palette base for entry 16.
// - Entry holds blue 3-0, green 7-4, red 11-8, blank bit 12, contrast bit 13.
// - Entries 0-15 are fixed colours; only entries 16 and up come from RAM.
// - Group field is three bits; 4-bit glyphs wrap codes 4-7 onto groups 0-3.
package osdp_pkg;

  // Glyph cell geometry
  localparam logic [3:0] BASE_H   = 4'h9;
  localparam logic [7:0] CELL_W   = 8'h0c;
  localparam logic [3:0] LAST_COL = 4'hb;

  // Palette layout
  localparam logic [5:0] PAL_PROG  = 6'h10;
  localparam int         BLUE_LSB  = 0;
  localparam int         GREEN_LSB = 4;
  localparam int         RED_LSB   = 8;
  localparam int         BLANK_BIT = 12;
  localparam int         COR_BIT   = 13;

  // Hardwired colour levels
  localparam logic [3:0] HW_FULL = 4'hf;
  localparam logic [3:0] HW_HALF = 4'h7;

  // Glyph source of a character
  typedef enum logic [1:0] {
    OSDP_ROM,
    OSDP_MONO,
    OSDP_TWO,
    OSDP_FOUR
  } osdp_kind_t;

  // Per-character attribute
  typedef struct packed {
    osdp_kind_t  kind;
    logic [2:0]  grp;
    logic [2:0]  fgc;
    logic [2:0]  bgc;
    logic [7:0]  code;
  } osdp_attr_t;

  // Global display settings
  typedef struct packed {
    logic [2:0]  soft_h;
    logic [2:0]  rom_h;
    logic        shadow_en;
    logic        shadow_dir;
    logic [5:0]  shadow_idx;
    logic        line_double;
    logic        hw_cor;
    logic        hw_blank;
  } osdp_gbl_t;

  // RAM base pointers
  typedef struct packed {
    logic [15:0] pal;
    logic [15:0] mono;
    logic [15:0] two;
    logic [15:0] four;
  } osdp_ptr_t;

  // Pixel token moving down the pipeline
  typedef struct packed {
    logic        vld;
    osdp_kind_t  kind;
    logic [2:0]  grp;
    logic [2:0]  fgc;
    logic [2:0]  bgc;
    logic [3:0]  col;
    logic [2:0]  bpos;
    logic [3:0]  val;
  } osdp_tok_t;

endpackage

//--- src/osdp_render.sv
// Pixel colour generation: glyph fetch, palette mapping, shadow and line doubling
`timescale 1ns/1ns
module osdp_render (
  // Clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               nrst_i,
  // Pixel stream
  input  wire logic               pix_vld_i,
  input  wire osdp_pkg::osdp_attr_t pix_attr_i,
  input  wire logic [3:0]         pix_col_i,
  input  wire logic [11:0]        rom_row_i,
  // Line timing
  input  wire logic               row_start_i,
  input  wire logic               line_end_i,
  input  wire logic               in_area_i,
  // Settings
  input  wire osdp_pkg::osdp_gbl_t  gbl_i,
  input  wire osdp_pkg::osdp_ptr_t  ptr_i,
  // Glyph RAM port
  output logic                    glyph_rd_o,
  output logic [15:0]             glyph_addr_o,
  input  wire logic [7:0]         glyph_data_i,
  // Palette RAM port
  output logic                    pal_rd_o,
  output logic [15:0]             pal_addr_o,
  input  wire logic [15:0]        pal_data_i,
  // Video out
  output logic                    rgb_vld_o,
  output logic [11:0]             rgb_o,
  output logic                    blank_o,
  output logic                    cor_o,
  output logic [3:0]              cell_line_o,
  output logic                    row_end_o
);
  import osdp_pkg::*;

  // Fixed colours of entries 0-15: low half full level, high half half level
  function automatic logic [11:0] hw_rgb(input logic [3:0] e);
    logic [3:0] lv;
    lv = e[3] ? HW_HALF : HW_FULL;
    hw_rgb = {e[0] ? lv : 4'h0, e[1] ? lv : 4'h0, e[2] ? lv : 4'h0};
  endfunction

  // Pull one pixel value out of a glyph byte; p is the pixel's first bit slot
  function automatic logic [3:0] px_get(input osdp_kind_t k, input logic [7:0] d,
                                        input logic [2:0] p);
    logic [3:0] v;
    v = 4'h0;
    case (k)
      OSDP_MONO: v[0] = d[3'd7 - p];
      OSDP_TWO: begin
        v[0] = d[3'd7 - p];
        v[1] = d[3'd6 - p];
      end
      OSDP_FOUR: begin
        for (int i = 0; i < 4; i++) begin
          v[i] = d[3'd7 - p - 3'(i)];
        end
      end
      default: v = 4'h0;
    endcase
    return v;
  endfunction

  // Line counter state
  logic [3:0]  line_r, line_nxt;
  logic        rep_r, rep_nxt;
  logic        row_end_nxt;
  logic [3:0]  line_last;

  // Pipeline state
  osdp_tok_t   tok_a_r, tok_a_nxt, tok_b_r, tok_bx, tok_c_r, tok_d_r;
  logic        glyph_rd_nxt, pal_rd_nxt, shd_c, shd_d_r, vld_e_r;
  logic [15:0] glyph_addr_nxt, pal_addr_nxt, base;
  logic [5:0]  idx_c, idx_d_r, idx_e_r;
  logic [1:0]  sh;
  logic [7:0]  bit_idx, cell_bits;
  logic [9:0]  bit_sh;
  logic [6:0]  bpc;
  logic        rom_bit, cast_c;
  logic [11:0] rgb_nxt;
  logic        blank_nxt, cor_nxt;

  // Row line counting; only soft height sets the row length
  always_comb begin
    line_last   = BASE_H - 4'h1 + {1'b0, gbl_i.soft_h};
    line_nxt    = line_r;
    rep_nxt     = rep_r;
    row_end_nxt = 1'b0;
    if (row_start_i) begin
      line_nxt = 4'h0;
      rep_nxt  = 1'b0;
    end else if (line_end_i && in_area_i) begin
      if (gbl_i.line_double && !rep_r) begin
        rep_nxt = 1'b1;
      end else begin
        rep_nxt = 1'b0;
        if (line_r == line_last) begin
          line_nxt    = 4'h0;
          row_end_nxt = 1'b1;
        end else begin
          line_nxt = line_r + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      line_r      <= 4'h0;
      rep_r       <= 1'b0;
      row_end_o   <= 1'b0;
      cell_line_o <= 4'h0;
    end else begin
      line_r      <= line_nxt;
      rep_r       <= rep_nxt;
      row_end_o   <= row_end_nxt;
      cell_line_o <= line_nxt;
    end
  end

  // Stage a: glyph address; every glyph is a whole number of bytes
  always_comb begin
    case (pix_attr_i.kind)
      OSDP_FOUR: sh = 2'd2;
      OSDP_TWO:  sh = 2'd1;
      default:   sh = 2'd0;
    endcase
    case (pix_attr_i.kind)
      OSDP_FOUR: base = ptr_i.four;
      OSDP_TWO:  base = ptr_i.two;
      default:   base = ptr_i.mono;
    endcase
    bit_idx   = 8'({4'h0, line_r} * CELL_W) + {4'h0, pix_col_i};
    bit_sh    = 10'({2'b00, bit_idx} << sh);
    // Height sum needs five bits: code 7 gives 16 lines, which a 4-bit sum wraps to 0
    cell_bits = 8'(({4'h0, BASE_H} + {5'h00, gbl_i.soft_h}) * CELL_W);
    bpc       = 7'((10'({2'b00, cell_bits} << sh) + 10'h007) >> 3);
    glyph_addr_nxt = base + 16'(pix_attr_i.code) * 16'(bpc)
                     + 16'(bit_sh[9:3]);
    // Lines past the ROM glyph height read as background
    rom_bit = ({1'b0, line_r} < {1'b0, BASE_H} + {2'b00, gbl_i.rom_h})
              && rom_row_i[LAST_COL - pix_col_i];
    tok_a_nxt      = '0;
    tok_a_nxt.vld  = pix_vld_i;
    tok_a_nxt.kind = pix_attr_i.kind;
    tok_a_nxt.grp  = pix_attr_i.grp;
    tok_a_nxt.fgc  = pix_attr_i.fgc;
    tok_a_nxt.bgc  = pix_attr_i.bgc;
    tok_a_nxt.col  = pix_col_i;
    tok_a_nxt.bpos = bit_sh[2:0];
    tok_a_nxt.val  = {3'b000, rom_bit};
    glyph_rd_nxt   = pix_vld_i && (pix_attr_i.kind != OSDP_ROM);
  end

  // Stage b: glyph byte arrives one cycle after the read strobe
  always_comb begin
    tok_bx = tok_b_r;
    if (tok_b_r.kind != OSDP_ROM) begin
      tok_bx.val = px_get(tok_b_r.kind, glyph_data_i, tok_b_r.bpos);
    end
  end

  // Stage c: shadow from the neighbour pixel and palette index
  always_comb begin
    // Adjacent columns share a cell, so the shadow cannot leak across cells
    if (!gbl_i.shadow_dir) begin
      cast_c = tok_d_r.vld && (tok_d_r.col + 4'h1 == tok_c_r.col)
               && tok_d_r.val[0];
    end else begin
      cast_c = tok_bx.vld && (tok_bx.col == tok_c_r.col + 4'h1)
               && tok_bx.val[0];
    end
    shd_c = gbl_i.shadow_en && !tok_c_r.val[0] && cast_c
            && (tok_c_r.kind == OSDP_ROM || tok_c_r.kind == OSDP_MONO);
    case (tok_c_r.kind)
      OSDP_TWO:  idx_c = PAL_PROG + 6'({tok_c_r.grp, tok_c_r.val[1:0]});
      OSDP_FOUR: idx_c = {tok_c_r.grp[1:0], tok_c_r.val};
      default:   idx_c = {tok_c_r.grp,
                          tok_c_r.val[0] ? tok_c_r.fgc : tok_c_r.bgc};
    endcase
    if (shd_c) begin
      idx_c = gbl_i.shadow_idx;
    end
    // Only programmable entries touch RAM, two bytes apart
    pal_rd_nxt   = tok_c_r.vld && (idx_c >= PAL_PROG);
    pal_addr_nxt = ptr_i.pal + 16'({idx_c - PAL_PROG, 1'b0});
  end

  // Output: fixed or RAM colour, overlay bits go straight to the pins
  always_comb begin
    if (!vld_e_r) begin
      rgb_nxt   = 12'h000;
      blank_nxt = gbl_i.hw_blank;
      cor_nxt   = gbl_i.hw_cor;
    end else if (idx_e_r < PAL_PROG) begin
      rgb_nxt   = hw_rgb(idx_e_r[3:0]);
      blank_nxt = gbl_i.hw_blank;
      cor_nxt   = gbl_i.hw_cor;
    end else begin
      rgb_nxt   = {pal_data_i[RED_LSB +: 4], pal_data_i[GREEN_LSB +: 4],
                   pal_data_i[BLUE_LSB +: 4]};
      blank_nxt = pal_data_i[BLANK_BIT];
      cor_nxt   = pal_data_i[COR_BIT];
    end
  end

  // Pipeline registers; a new pixel may enter every clock
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      tok_a_r      <= '0;
      tok_b_r      <= '0;
      tok_c_r      <= '0;
      tok_d_r      <= '0;
      shd_d_r      <= 1'b0;
      idx_d_r      <= 6'h00;
      vld_e_r      <= 1'b0;
      idx_e_r      <= 6'h00;
      glyph_rd_o   <= 1'b0;
      glyph_addr_o <= 16'h0000;
      pal_rd_o     <= 1'b0;
      pal_addr_o   <= 16'h0000;
      rgb_vld_o    <= 1'b0;
      rgb_o        <= 12'h000;
      blank_o      <= 1'b0;
      cor_o        <= 1'b0;
    end else begin
      tok_a_r      <= tok_a_nxt;
      tok_b_r      <= tok_a_r;
      tok_c_r      <= tok_bx;
      tok_d_r      <= tok_c_r;
      shd_d_r      <= shd_c;
      idx_d_r      <= idx_c;
      vld_e_r      <= tok_d_r.vld;
      idx_e_r      <= idx_d_r;
      glyph_rd_o   <= glyph_rd_nxt;
      glyph_addr_o <= glyph_addr_nxt;
      pal_rd_o     <= pal_rd_nxt;
      pal_addr_o   <= pal_addr_nxt;
      rgb_vld_o    <= vld_e_r;
      rgb_o        <= rgb_nxt;
      blank_o      <= blank_nxt;
      cor_o        <= cor_nxt;
    end
  end

  // Checks on the pipeline and counters
  pipe_latency_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    pix_vld_i |-> ##6 rgb_vld_o) else $error("pixel lost in pipeline");
  glyph_fetch_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    pix_vld_i && pix_attr_i.kind != OSDP_ROM |=> glyph_rd_o)
    else $error("soft glyph not fetched");
  mono_index_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    tok_d_r.vld && !shd_d_r && tok_d_r.kind == OSDP_MONO
    |-> idx_d_r == {tok_d_r.grp, tok_d_r.val[0] ? tok_d_r.fgc : tok_d_r.bgc})
    else $error("1-bit index wrong");
  two_index_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    tok_d_r.vld && tok_d_r.kind == OSDP_TWO
    |-> idx_d_r == 6'h10 + {1'b0, tok_d_r.grp, tok_d_r.val[1:0]})
    else $error("2-bit index wrong");
  four_index_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    tok_d_r.vld && tok_d_r.kind == OSDP_FOUR
    |-> idx_d_r[5:4] == tok_d_r.grp[1:0] && idx_d_r[3:0] == tok_d_r.val)
    else $error("4-bit index wrong");
  shadow_kind_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    shd_d_r |-> gbl_i.shadow_en && !tok_d_r.val[0]
    && (tok_d_r.kind == OSDP_ROM || tok_d_r.kind == OSDP_MONO))
    else $error("shadow on wrong glyph");
  hw_entry_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    tok_c_r.vld ##1 idx_d_r < 6'h10 |-> !pal_rd_o)
    else $error("fixed entry read from RAM");
  row_wrap_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    row_end_o |-> cell_line_o == 4'h0
    && $past(line_r) == 4'h8 + {1'b0, $past(gbl_i.soft_h)})
    else $error("row length wrong");
  line_repeat_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    line_end_i && in_area_i && gbl_i.line_double && !rep_r && !row_start_i
    |=> $stable(line_r) ##0 rep_r) else $error("line not doubled");

  // Checks on fill lines, shadow colour and enable, palette addressing, line counting outside the area and pin levels
  rom_fill_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    pix_vld_i && pix_attr_i.kind == OSDP_ROM
    && {1'b0, line_r} >= 5'h09 + {2'b00, gbl_i.rom_h} |=> tok_a_r.val == 4'h0)
    else $error("ROM fill line not background");
  shadow_colour_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    shd_d_r |-> idx_d_r == $past(gbl_i.shadow_idx))
    else $error("shadow colour index wrong");
  shadow_off_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !gbl_i.shadow_en |=> !shd_d_r)
    else $error("shadow drawn while disabled");
  pal_addr_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    pal_rd_o |-> pal_addr_o == ptr_i.pal + {9'h000, idx_d_r - 6'h10, 1'b0})
    else $error("palette address wrong");
  area_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    line_end_i && !in_area_i && !row_start_i |=> $stable(line_r) && $stable(rep_r))
    else $error("line counted outside display area");
  idle_level_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !vld_e_r |=> rgb_o == 12'h000 && blank_o == $past(gbl_i.hw_blank)
    && cor_o == $past(gbl_i.hw_cor))
    else $error("idle pin levels wrong");
  ram_colour_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    vld_e_r && idx_e_r >= 6'h10 |=> rgb_o == $past(pal_data_i[11:0])
    && blank_o == $past(pal_data_i[BLANK_BIT]) && cor_o == $past(pal_data_i[COR_BIT]))
    else $error("programmable entry not passed to pins");

endmodule

//--- dv/osdp_ram_model.sv
// Behavioural glyph and palette RAM standing beside the pixel colour stage
`timescale 1ns/1ns
module osdp_ram_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Glyph byte port
  input  wire logic        glyph_rd_i,
  input  wire logic [15:0] glyph_addr_i,
  output logic [7:0]       glyph_data_o,
  // Palette word port
  input  wire logic        pal_rd_i,
  input  wire logic [15:0] pal_addr_i,
  output logic [15:0]      pal_data_o
);
  // Byte store loaded by the bench; 4 KB folds the 16-bit space
  logic [7:0] mem [0:4095];

  initial begin
    glyph_data_o = 8'h00;
    pal_data_o = 16'h0000;
  end

  // One-cycle read; between reads the data toggles so a stale sample cannot pass
  always @(posedge clk_sys_i) begin
    glyph_data_o <= glyph_rd_i ? mem[glyph_addr_i[11:0]] : ~glyph_data_o;
    pal_data_o <= pal_rd_i ? {mem[pal_addr_i[11:0] + 12'h001],
                              mem[pal_addr_i[11:0]]} : ~pal_data_o;
  end
endmodule

//--- dv/osdp_render_tb.sv
// Self-checking bench for the OSD pixel colour stage
`timescale 1ns/1ns
module osdp_render_tb;
  import osdp_pkg::*;
  // Stimulus
  logic        clk_sys_i   = 1'b0;
  logic        nrst_i      = 1'b0;
  logic        pix_vld_i   = 1'b0;
  osdp_attr_t  pix_attr_i  = '0;
  logic [3:0]  pix_col_i   = 4'h0;
  logic [11:0] rom_row_i   = 12'h000;
  logic        row_start_i = 1'b0;
  logic        line_end_i  = 1'b0;
  logic        in_area_i   = 1'b1;
  osdp_gbl_t   gbl_i       = '0;
  osdp_ptr_t   ptr_i       = {16'h0100, 16'h0200, 16'h0400, 16'h0800};
  // Design outputs
  logic        glyph_rd_o, pal_rd_o, rgb_vld_o, blank_o, cor_o, row_end_o;
  logic [15:0] glyph_addr_o, pal_addr_o, pal_data_i;
  logic [7:0]  glyph_data_i;
  logic [11:0] rgb_o;
  logic [3:0]  cell_line_o;
  // Reference state
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          lc;
  bit          rep;
  logic [13:0] exp_q[$];
  int          due_q[$];
  osdp_attr_t  at [0:2];
  logic [11:0] rr [0:2];
  logic [3:0]  v [0:35];

  osdp_render dut_u (.clk_sys_i, .nrst_i, .pix_vld_i, .pix_attr_i, .pix_col_i, .rom_row_i,
    .row_start_i, .line_end_i, .in_area_i, .gbl_i, .ptr_i, .glyph_rd_o, .glyph_addr_o,
    .glyph_data_i, .pal_rd_o, .pal_addr_o, .pal_data_i, .rgb_vld_o, .rgb_o, .blank_o,
    .cor_o, .cell_line_o, .row_end_o);

  osdp_ram_model ram_u (.clk_sys_i, .glyph_rd_i(glyph_rd_o), .glyph_addr_i(glyph_addr_o),
    .glyph_data_o(glyph_data_i), .pal_rd_i(pal_rd_o), .pal_addr_i(pal_addr_o),
    .pal_data_o(pal_data_i));

  always #5 clk_sys_i = ~clk_sys_i;

  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Stored pixel value of column col on the current glyph line
  function automatic logic [3:0] pix_val(osdp_attr_t a, int col, logic [11:0] r);
    int bpp, base, bits, b;
    logic [7:0] by;
    if (a.kind == OSDP_ROM) return (lc >= 9 + gbl_i.rom_h) ? 4'h0 : {3'h0, r[11 - col]};
    bpp = (a.kind == OSDP_MONO) ? 1 : (a.kind == OSDP_TWO) ? 2 : 4;
    base = (a.kind == OSDP_MONO) ? ptr_i.mono : (a.kind == OSDP_TWO) ? ptr_i.two : ptr_i.four;
    bits = (lc * 12 + col) * bpp;
    by = ram_u.mem[12'(base + a.code * (((9 + gbl_i.soft_h) * 12 * bpp + 7) / 8) + bits / 8)];
    b = 7 - bits % 8;
    if (bpp == 1) return {3'h0, by[b]};
    if (bpp == 2) return {2'h0, by[b - 1], by[b]};
    return {by[b - 3], by[b - 2], by[b - 1], by[b]};
  endfunction

  // Colour, blank and contrast levels of a palette entry
  function automatic logic [13:0] colour(logic [5:0] idx);
    logic [3:0]  lv;
    logic [11:0] a;
    lv = idx[3] ? 4'h7 : 4'hf;
    a = ptr_i.pal[11:0] + 12'(2 * (idx - 16));
    if (idx < 6'h10) return {gbl_i.hw_cor, gbl_i.hw_blank, idx[0] ? lv : 4'h0,
                             idx[1] ? lv : 4'h0, idx[2] ? lv : 4'h0};
    return {ram_u.mem[a + 12'h001][5:0], ram_u.mem[a]};
  endfunction

  // One line of three random cells, driven back to back
  task automatic run_line();
    logic [5:0] idx;
    logic       nb;
    osdp_attr_t a;
    for (int c = 0; c < 3; c++) begin
      at[c] = osdp_attr_t'(19'($urandom));
      at[c].code = {6'h00, at[c].code[1:0]};
      rr[c] = 12'($urandom);
      for (int k = 0; k < 12; k++) v[c * 12 + k] = pix_val(at[c], k, rr[c]);
    end
    for (int p = 0; p < 36; p++) begin
      a = at[p / 12];
      nb = gbl_i.shadow_dir ? (p % 12 < 11 && v[p + 1][0]) : (p % 12 > 0 && v[p - 1][0]);
      if (a.kind == OSDP_TWO) idx = 6'h10 + {1'b0, a.grp, v[p][1:0]};
      else if (a.kind == OSDP_FOUR) idx = {a.grp[1:0], v[p]};
      else if (v[p][0]) idx = {a.grp, a.fgc};
      else idx = (gbl_i.shadow_en && nb) ? gbl_i.shadow_idx : {a.grp, a.bgc};
      pix_vld_i = 1'b1;
      pix_attr_i = a;
      pix_col_i = 4'(p % 12);
      rom_row_i = rr[p / 12];
      exp_q.push_back(colour(idx));
      due_q.push_back(cyc + 6);
      tick();
    end
    pix_vld_i = 1'b0;
    repeat (8) tick();
  endtask

  // Line end pulse, inside or outside the display area
  task automatic le(input logic ia);
    logic wr;
    line_end_i = 1'b1;
    in_area_i = ia;
    wr = 1'b0;
    if (ia && gbl_i.line_double && !rep) rep = 1'b1;
    else if (ia) begin
      rep = 1'b0;
      wr = (lc == 8 + gbl_i.soft_h);
      lc = wr ? 0 : lc + 1;
    end
    tick();
    line_end_i = 1'b0;
    in_area_i = 1'b1;
    // The wrap pulse stands only in the cycle after the sampling edge
    chk("cell_line_o", lc, cell_line_o);
    chk("row_end_o", wr, row_end_o);
    tick();
  endtask

  // Result monitor; samples after the edge's updates have landed
  always @(posedge clk_sys_i) begin
    cyc++;
    #2;
    if (rgb_vld_o === 1'b1) begin
      if (exp_q.size() == 0) chk("rgb_vld_o", 0, 1);
      else begin
        chk("latency", due_q.pop_front(), cyc);
        chk("pixel", exp_q.pop_front(), {cor_o, blank_o, rgb_o});
      end
    end else if (nrst_i === 1'b1) chk("idle rgb_o", 0, rgb_o);
  end

  // Watchdog well beyond the expected 7326 cycles
  initial begin
    #500000;
    error_cnt++;
    finish_test();
  end

  initial begin
    void'($urandom(73));
    for (int i = 0; i < 4096; i++) ram_u.mem[i] = 8'($urandom);
    repeat (4) tick();
    chk("reset rgb_vld_o", 0, rgb_vld_o);
    nrst_i = 1'b1;
    // Every soft height code; doubling and both shadow senses spread over the set
    for (int cfg = 0; cfg < 8; cfg++) begin
      gbl_i = osdp_gbl_t'(17'($urandom));
      gbl_i.soft_h = 3'(cfg);
      gbl_i.line_double = cfg[0];
      gbl_i.shadow_en = cfg[1] | cfg[2];
      gbl_i.shadow_dir = cfg[2];
      row_start_i = 1'b1;
      tick();
      row_start_i = 1'b0;
      tick();
      lc = 0;
      rep = 1'b0;
      chk("cell_line_o", 0, cell_line_o);
      repeat ((9 + cfg) * (1 + cfg[0])) begin
        run_line();
        le(1'b0);
        le(1'b1);
      end
    end
    repeat (10) tick();
    chk("pending", 0, exp_q.size());
    finish_test();
  end
endmodule
